/* include/pcxd_pkg.sv */
// Package for the priority crossbar: register indices, field positions, function order.
// Assumes a 16-pin pair of 8-bit ports and a classic Wishbone register bus.
package pcxd_pkg;
  localparam int unsigned NUM_PINS   = 16;
  localparam int unsigned NUM_FUNCS  = 17;
  localparam int unsigned PIN_W      = 4;
  localparam int unsigned ADR_W      = 10;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_EN_A    = 8'he1;
  localparam logic [7:0] IDX_EN_B    = 8'he2;
  localparam logic [7:0] IDX_EN_C    = 8'he3;
  localparam logic [7:0] IDX_SKIP_0  = 8'hd4;
  localparam logic [7:0] IDX_SKIP_1  = 8'hd5;
  localparam logic [7:0] IDX_MODE_0  = 8'ha4;
  localparam logic [7:0] IDX_MODE_1  = 8'ha5;
  localparam logic [7:0] IDX_SPI_CTL = 8'hf8;

  // Writable masks and reset values
  localparam logic [7:0] EN_A_MASK   = 8'h3f;
  localparam logic [7:0] EN_B_MASK   = 8'h3f;
  localparam logic [7:0] EN_C_MASK   = 8'h40;
  localparam logic [7:0] SPI_MASK    = 8'h0c;
  localparam logic [7:0] REG_RESET   = 8'h00;

  // Field positions
  localparam int unsigned A_UART     = 0;
  localparam int unsigned A_SPI      = 1;
  localparam int unsigned A_SMB      = 2;
  localparam int unsigned A_SYSCK    = 3;
  localparam int unsigned A_CPS      = 4;
  localparam int unsigned A_CPA      = 5;
  localparam int unsigned B_CEX_LO   = 0;
  localparam int unsigned B_ECI      = 3;
  localparam int unsigned B_T0       = 4;
  localparam int unsigned B_T1       = 5;
  localparam int unsigned C_XBAR_EN  = 6;
  localparam int unsigned SPI_NSS_LO = 2;

  localparam logic [2:0] CEX_NONE    = 3'h0;
  localparam logic [2:0] CEX_ONE     = 3'h1;
  localparam logic [2:0] CEX_TWO     = 3'h2;
  localparam logic [2:0] CEX_THREE   = 3'h3;
  localparam logic [1:0] NSS_3WIRE   = 2'h0;

  // Fixed UART pins
  localparam logic [PIN_W-1:0] UART_TX_PIN = 4'h4;
  localparam logic [PIN_W-1:0] UART_RX_PIN = 4'h5;

  // Function order, highest priority first
  localparam int unsigned F_TX   = 0;
  localparam int unsigned F_RX   = 1;
  localparam int unsigned F_SCK  = 2;
  localparam int unsigned F_MISO = 3;
  localparam int unsigned F_MOSI = 4;
  localparam int unsigned F_NSS  = 5;
  localparam int unsigned F_SDA  = 6;
  localparam int unsigned F_SCL  = 7;
  localparam int unsigned F_CPS  = 8;
  localparam int unsigned F_CPA  = 9;
  localparam int unsigned F_SYSCK = 10;
  localparam int unsigned F_CAPTURE_CHANNEL_0 = 11;
  localparam int unsigned F_CAPTURE_CHANNEL_1 = 12;
  localparam int unsigned F_CAPTURE_CHANNEL_2 = 13;
  localparam int unsigned F_ECI  = 14;
  localparam int unsigned F_T0   = 15;
  localparam int unsigned F_T1   = 16;

  typedef struct packed {
    logic [7:0]          en_a;
    logic [7:0]          en_b;
    logic [7:0]          en_c;
    logic [NUM_PINS-1:0] skip;
    logic [NUM_PINS-1:0] mode;
    logic [7:0]          spi_ctl;
    logic                ack;
    logic [31:0]         dat;
    logic [NUM_PINS-1:0] pad_out;
    logic [NUM_PINS-1:0] pad_oe;
    logic [NUM_FUNCS-1:0] func_in;
  } pcxd_state_type;
endpackage : pcxd_pkg

/* src/pcxd_crossbar.sv */
// Priority crossbar routing peripheral signals onto two 8-bit ports.
// Assumes synchronous pad inputs, peripherals giving out/oe per function, Wishbone master.
// Notes on behaviour
// - Enabled functions after UART walked in priority order, each takes lowest free pin.
// - A pin once given is passed over for all later functions.
// - Pins with skip bit set count as already taken.
// - UART transmit always on P0.4, receive on P0.5.
// - UART always gets both pins of its pair; two-wire bus gets both only when two pins are still free.
// - Unclaimed pins stay general purpose, following their GPIO latch.
// - Global enable clear keeps every pin driver off.
// - Routed two-wire pins forced open-drain over per-pin mode.
// - Slave select gets a pin only in four-wire mode.
// - Three or four wire choice shifts pins of lower functions.
// - Enable A bits 7:6 read zero, writes ignored.
// - Enable A bit 5 routes asynchronous comparator output.
// - Enable A bit 4 routes synchronous comparator output.
// - Enable A bit 3 puts system clock on a pin.
// - Enable A bit 2 routes two-wire data and clock.
// - Enable A bit 1 routes SPI clock, MISO, MOSI; select if four-wire.
// - Enable A bit 0 puts UART on its fixed pins.
// - Enable B bits 7:6 read zero, writes ignored.
// - Enable B bit 5 routes Timer1 input, bit 4 Timer0 input.
// - Enable B bit 3 routes counter array count input.
// - Enable B bits 2:0 route zero to three capture channels; 4-7 reserved.
// - Both enable registers reset to zero; nothing routed.
module pcxd_crossbar
  import pcxd_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Peripheral side
  input  wire logic [NUM_FUNCS-1:0] func_out_i,
  input  wire logic [NUM_FUNCS-1:0] func_oe_i,
  output logic      [NUM_FUNCS-1:0] func_in_o,
  // Pad side
  input  wire logic [NUM_PINS-1:0]  gpio_latch_i,
  input  wire logic [NUM_PINS-1:0]  pad_in_i,
  output logic      [NUM_PINS-1:0]  pad_out_o,
  output logic      [NUM_PINS-1:0]  pad_oe_o
);

  pcxd_state_type st_q;
  pcxd_state_type st_d;

  logic [NUM_FUNCS-1:0] fn_en;
  logic [NUM_FUNCS-1:0] fn_has;
  logic [PIN_W-1:0]     fn_pin [NUM_FUNCS];
  logic [NUM_PINS-1:0]  taken;
  logic [NUM_PINS-1:0]  pin_own;
  logic [4:0]           pin_fn [NUM_PINS];
  logic                 xbar_en;
  logic                 four_wire;
  logic                 req;
  logic [7:0]           idx;

  // Lowest free pin in a taken mask
  function automatic logic [PIN_W:0] first_free(input logic [NUM_PINS-1:0] t);
    logic [PIN_W:0] r;
    r = '0;
    for (int p = NUM_PINS - 1; p >= 0; p--) begin
      if (!t[p]) begin
        r = {1'b1, PIN_W'(p)};
      end
    end
    return r;
  endfunction

  // Register write with fixed mask
  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] mask);
    return (old & ~mask) | (wb_dat_i[7:0] & mask);
  endfunction

  assign xbar_en   = st_q.en_c[C_XBAR_EN];
  assign four_wire = st_q.spi_ctl[SPI_NSS_LO +: 2] != NSS_3WIRE;
  assign req       = wb_cyc_i && wb_stb_i;
  assign idx       = wb_adr_i[ADR_W-1:2];

  // Function enables from the enable registers
  always_comb begin
    fn_en          = '0;
    fn_en[F_TX]    = st_q.en_a[A_UART];
    fn_en[F_RX]    = st_q.en_a[A_UART];
    fn_en[F_SCK]   = st_q.en_a[A_SPI];
    fn_en[F_MISO]  = st_q.en_a[A_SPI];
    fn_en[F_MOSI]  = st_q.en_a[A_SPI];
    fn_en[F_NSS]   = st_q.en_a[A_SPI] && four_wire;
    fn_en[F_SDA]   = st_q.en_a[A_SMB];
    fn_en[F_SCL]   = st_q.en_a[A_SMB];
    fn_en[F_CPS]   = st_q.en_a[A_CPS];
    fn_en[F_CPA]   = st_q.en_a[A_CPA];
    fn_en[F_SYSCK] = st_q.en_a[A_SYSCK];
    unique case (st_q.en_b[B_CEX_LO +: 3])
      CEX_ONE:   fn_en[F_CAPTURE_CHANNEL_0 +: 3] = 3'h1;
      CEX_TWO:   fn_en[F_CAPTURE_CHANNEL_0 +: 3] = 3'h3;
      CEX_THREE: fn_en[F_CAPTURE_CHANNEL_0 +: 3] = 3'h7;
      default:   fn_en[F_CAPTURE_CHANNEL_0 +: 3] = 3'h0;
    endcase
    fn_en[F_ECI]   = st_q.en_b[B_ECI];
    fn_en[F_T0]    = st_q.en_b[B_T0];
    fn_en[F_T1]    = st_q.en_b[B_T1];
  end

  // Priority walk over live register contents
  always_comb begin
    logic [PIN_W:0] ff;
    ff     = '0;
    taken  = st_q.skip;
    fn_has = '0;
    for (int f = 0; f < NUM_FUNCS; f++) begin
      fn_pin[f] = '0;
    end
    if (fn_en[F_TX]) begin
      taken[UART_TX_PIN] = 1'b1;
      taken[UART_RX_PIN] = 1'b1;
    end
    fn_has[F_TX] = fn_en[F_TX];
    fn_has[F_RX] = fn_en[F_RX];
    fn_pin[F_TX] = UART_TX_PIN;
    fn_pin[F_RX] = UART_RX_PIN;
    for (int f = F_SCK; f < NUM_FUNCS; f++) begin
      if (fn_en[f]) begin
        ff        = first_free(taken);
        fn_has[f] = ff[PIN_W];
        fn_pin[f] = ff[PIN_W-1:0];
        if (ff[PIN_W]) begin
          taken[ff[PIN_W-1:0]] = 1'b1;
        end
      end
    end
  end

  // Pin ownership map
  always_comb begin
    pin_own = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_fn[p] = '0;
    end
    for (int f = 0; f < NUM_FUNCS; f++) begin
      if (fn_has[f]) begin
        pin_own[fn_pin[f]] = 1'b1;
        pin_fn[fn_pin[f]]  = 5'(f);
      end
    end
  end

  // Next state
  always_comb begin
    logic od;
    logic val;
    logic drv;
    od   = 1'b0;
    val  = 1'b0;
    drv  = 1'b0;
    st_d = st_q;
    // Bus: ack one cycle after request, write at the acknowledged edge
    st_d.ack = req && !st_q.ack;
    st_d.dat = '0;
    unique case (idx)
      IDX_EN_A:    st_d.dat[7:0] = st_q.en_a;
      IDX_EN_B:    st_d.dat[7:0] = st_q.en_b;
      IDX_EN_C:    st_d.dat[7:0] = st_q.en_c;
      IDX_SKIP_0:  st_d.dat[7:0] = st_q.skip[7:0];
      IDX_SKIP_1:  st_d.dat[7:0] = st_q.skip[15:8];
      IDX_MODE_0:  st_d.dat[7:0] = st_q.mode[7:0];
      IDX_MODE_1:  st_d.dat[7:0] = st_q.mode[15:8];
      IDX_SPI_CTL: st_d.dat[7:0] = st_q.spi_ctl;
      default:     st_d.dat[7:0] = 8'h00;
    endcase
    if (req && st_q.ack && wb_we_i && wb_sel_i[0]) begin
      unique case (idx)
        IDX_EN_A:    st_d.en_a       = wr_byte(st_q.en_a, EN_A_MASK);
        IDX_EN_B:    st_d.en_b       = wr_byte(st_q.en_b, EN_B_MASK);
        IDX_EN_C:    st_d.en_c       = wr_byte(st_q.en_c, EN_C_MASK);
        IDX_SKIP_0:  st_d.skip[7:0]  = wb_dat_i[7:0];
        IDX_SKIP_1:  st_d.skip[15:8] = wb_dat_i[7:0];
        IDX_MODE_0:  st_d.mode[7:0]  = wb_dat_i[7:0];
        IDX_MODE_1:  st_d.mode[15:8] = wb_dat_i[7:0];
        IDX_SPI_CTL: st_d.spi_ctl    = wr_byte(st_q.spi_ctl, SPI_MASK);
        default:     st_d.dat        = st_d.dat;
      endcase
    end
    // Pads
    for (int p = 0; p < NUM_PINS; p++) begin
      if (pin_own[p]) begin
        od  = (pin_fn[p] == 5'(F_SDA)) || (pin_fn[p] == 5'(F_SCL)) || !st_q.mode[p];
        val = func_out_i[pin_fn[p]];
        drv = func_oe_i[pin_fn[p]];
      end else begin
        od  = !st_q.mode[p];
        val = gpio_latch_i[p];
        drv = 1'b1;
      end
      st_d.pad_out[p] = val;
      st_d.pad_oe[p]  = xbar_en && drv && (!od || !val);
    end
    // Peripheral inputs idle high when unrouted
    for (int f = 0; f < NUM_FUNCS; f++) begin
      st_d.func_in[f] = fn_has[f] ? pad_in_i[fn_pin[f]] : 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q         <= '0;
      st_q.en_a    <= REG_RESET;
      st_q.en_b    <= REG_RESET;
      st_q.func_in <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_ack_o  = st_q.ack;
  assign wb_dat_o  = st_q.dat;
  assign pad_out_o = st_q.pad_out;
  assign pad_oe_o  = st_q.pad_oe;
  assign func_in_o = st_q.func_in;

  xbar_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(xbar_en) && !$past(rst_i) |-> pad_oe_o == '0)
    else $error("Pad driven while crossbar disabled");

  uart_fixed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(fn_has[F_TX]) |-> pad_out_o[UART_TX_PIN] == $past(func_out_i[F_TX]))
    else $error("UART transmit not on its fixed pin");

  rx_fixed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(fn_has[F_RX]) |-> func_in_o[F_RX] == $past(pad_in_i[UART_RX_PIN]))
    else $error("UART receive not from its fixed pin");

  lowest_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fn_en[F_SCK] && !fn_en[F_TX] && st_q.skip == '0 |-> fn_has[F_SCK] && fn_pin[F_SCK] == '0)
    else $error("First function not on lowest pin");

  no_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fn_en & ~fn_has) != '0 |-> &taken)
    else $error("Enabled function unrouted while a pin is free");

  no_reuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fn_has[F_SCK] && fn_has[F_MISO] |-> fn_pin[F_MISO] > fn_pin[F_SCK])
    else $error("Pin reused by later function");

  one_owner_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $countones(pin_own) == $countones(fn_has))
    else $error("Two functions share a pin");

  skip_honor_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fn_has[F_SCK] |-> !st_q.skip[fn_pin[F_SCK]])
    else $error("Skipped pin assigned");

  skip_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !fn_has[F_TX] |-> (pin_own & st_q.skip) == '0)
    else $error("Skipped pin given to a function");

  pair_both_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fn_en[F_SDA] && $countones(~st_q.skip) >= 16 |-> fn_has[F_SDA] && fn_has[F_SCL])
    else $error("Two-wire pair split");

  gpio_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i)
    |-> (pad_out_o & ~$past(pin_own)) == ($past(gpio_latch_i) & ~$past(pin_own)))
    else $error("Unrouted pin not following its latch");

  gpio_contig_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !fn_en[F_TX] && st_q.skip == '0 |-> (pin_own & (pin_own + NUM_PINS'(1))) == '0)
    else $error("Routed pins not contiguous");

  open_drain_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(fn_has[F_SDA]) && $past(func_out_i[F_SDA])
    |-> !pad_oe_o[$past(fn_pin[F_SDA])])
    else $error("Two-wire data driven high");

  od_scl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(fn_has[F_SCL]) && $past(func_out_i[F_SCL])
    |-> !pad_oe_o[$past(fn_pin[F_SCL])])
    else $error("Two-wire clock driven high");

  nss_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.en_a[A_SPI] && st_q.skip == '0 |-> fn_has[F_NSS] == four_wire)
    else $error("Slave select routing wrong");

  nss_shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.en_a[A_SPI] && st_q.en_a[A_SMB] && !fn_en[F_TX] && st_q.skip == '0
    |-> fn_pin[F_SDA] == fn_pin[F_MOSI] + PIN_W'(four_wire) + PIN_W'(1))
    else $error("Slave select mode did not shift later pins");

  en_a_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(req && st_q.ack && wb_we_i && wb_sel_i[0] && idx == IDX_EN_A)
    |-> st_q.en_a == ($past(wb_dat_i[7:0]) & EN_A_MASK))
    else $error("Enable A write not masked");

  reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.en_a[7:6] == 2'h0 && st_q.en_b[7:6] == 2'h0)
    else $error("Reserved enable bits set");

  cpa_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.skip == '0 |-> fn_has[F_CPA] == st_q.en_a[A_CPA])
    else $error("Asynchronous comparator routing wrong");

  cps_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.skip == '0 |-> fn_has[F_CPS] == st_q.en_a[A_CPS])
    else $error("Synchronous comparator routing wrong");

  system_clock_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.skip == '0 |-> fn_has[F_SYSCK] == st_q.en_a[A_SYSCK])
    else $error("System clock routing wrong");

  smb_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.skip == '0 |-> fn_has[F_SDA +: 2] == {2{st_q.en_a[A_SMB]}})
    else $error("Two-wire routing wrong");

  spi_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.skip == '0 |-> fn_has[F_SCK +: 3] == {3{st_q.en_a[A_SPI]}})
    else $error("SPI routing wrong");

  uart_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fn_has[F_TX +: 2] == {2{st_q.en_a[A_UART]}})
    else $error("UART routing wrong");

  en_b_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(req && st_q.ack && wb_we_i && wb_sel_i[0] && idx == IDX_EN_B)
    |-> st_q.en_b == ($past(wb_dat_i[7:0]) & EN_B_MASK))
    else $error("Enable B write not masked");

  t0_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.skip == '0 |-> fn_has[F_T0] == st_q.en_b[B_T0])
    else $error("Timer0 input routing wrong");

  eci_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.skip == '0 |-> fn_has[F_ECI] == st_q.en_b[B_ECI])
    else $error("Count input routing wrong");

  cex_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.skip == '0 |-> $countones(fn_has[F_CAPTURE_CHANNEL_0 +: 3]) == (st_q.en_b[2] ? 2'h0 : st_q.en_b[1:0]))
    else $error("Capture channel count wrong");

  cex_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fn_en[F_CAPTURE_CHANNEL_1] || fn_en[F_CAPTURE_CHANNEL_0]) && (!fn_en[F_CAPTURE_CHANNEL_2] || fn_en[F_CAPTURE_CHANNEL_1]))
    else $error("Capture channels not from channel 0 up");

  cex_res_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.en_b[2] |-> fn_en[F_CAPTURE_CHANNEL_0 +: 3] == 3'h0)
    else $error("Reserved channel code routed");

  reset_val_a: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> st_q.en_a == 8'h00 && st_q.en_b == 8'h00 && pad_oe_o == '0)
    else $error("Enable not cleared by reset");

  reset_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> func_in_o == '1 && !wb_ack_o && wb_dat_o == '0)
    else $error("Outputs not idle after reset");

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held two cycles");

  ack_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_ack_o |=> wb_ack_o)
    else $error("Acknowledge not given one cycle after request");

  rdata_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_dat_o[31:8] == '0)
    else $error("Upper read data bits not zero");

endmodule : pcxd_crossbar

/* tb/pcxd_partner.sv */
// Peripheral and pad partner model for the priority crossbar.
// Assumes the bench supplies peripheral values and outside pin levels.
module pcxd_partner
  import pcxd_pkg::*;
(
  // Stimulus
  input  wire logic [NUM_FUNCS-1:0] pat_i,
  input  wire logic [NUM_PINS-1:0]  ext_i,
  // Crossbar pad side
  input  wire logic [NUM_PINS-1:0]  pad_out_i,
  input  wire logic [NUM_PINS-1:0]  pad_oe_i,
  // Crossbar peripheral side and pad input
  output logic      [NUM_FUNCS-1:0] func_out_o,
  output logic      [NUM_FUNCS-1:0] func_oe_o,
  output logic      [NUM_PINS-1:0]  pad_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Receive, count and timer inputs never drive
  assign func_oe_o  = ~17'h1c002;
  assign func_out_o = pat_i;
  // Driven pins read back, others follow the outside circuit
  assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule // pcxd_partner

/* tb/priority_crossbar_decoder_tb.sv */
// Self-checking bench for the priority crossbar.
// Assumes the partner model on the pad and peripheral side.
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module priority_crossbar_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcxd_pkg::*;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 cyc = 1'b0;
  logic                 we = 1'b0;
  logic [ADR_W-1:0]     adr = '0;
  logic [3:0]           sel = 4'h0;
  logic [31:0]          wdat = 32'h0;
  logic [31:0]          rdat;
  logic [31:0]          seed = 32'h74aa;
  logic [NUM_FUNCS-1:0] pat = '0;
  logic [15:0]          latch = 16'h0;
  logic [15:0]          ext = 16'h0;
  logic [7:0]           ra = 8'h0, rb = 8'h0, rc = 8'h0, rspi = 8'h0;
  logic [15:0]          rskip = 16'h0, rmode = 16'h0;
  wire logic [31:0]     wb_dat_o;
  wire logic            wb_ack_o;
  wire logic [16:0]     f_out, f_oe, f_in;
  wire logic [15:0]     p_in, p_out, p_oe;
  int                   num_errors = 0;
  int                   check_count = 0;

  always #10 clk_i = ~clk_i;

  pcxd_crossbar uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .func_out_i(f_out), .func_oe_i(f_oe), .func_in_o(f_in),
    .gpio_latch_i(latch), .pad_in_i(p_in), .pad_out_o(p_out), .pad_oe_o(p_oe));
  pcxd_partner peer (.pat_i(pat), .ext_i(ext), .pad_out_i(p_out), .pad_oe_i(p_oe),
    .func_out_o(f_out), .func_oe_o(f_oe), .pad_in_o(p_in));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    sel <= {3'h0, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    rdat = wb_dat_o;
    cyc <= 1'b0;
  endtask

  task automatic check;
    int          pin [NUM_FUNCS];
    logic [15:0] tk, eo, ee, pi;
    logic [16:0] en, ei;
    en = {rb[5], rb[4], rb[3], rb[2:0] == 3'h3, rb[2:1] == 2'h1, !rb[2] && rb[1:0] != 2'h0,
          ra[3], ra[5], ra[4], ra[2], ra[2], ra[1] && rspi[3:2] != 2'h0, {3{ra[1]}}, 2'h0};
    tk = rskip;
    foreach (pin[f]) pin[f] = -1;
    if (ra[0]) begin
      pin[F_TX] = 4;
      pin[F_RX] = 5;
      tk[5:4] = 2'h3;
    end
    for (int f = 2; f < NUM_FUNCS; f++)
      for (int p = 0; p < NUM_PINS; p++)
        if (en[f] && !tk[p] && pin[f] < 0) begin
          pin[f] = p;
          tk[p] = 1'b1;
        end
    eo = latch;
    ee = rmode | ~latch;
    foreach (pin[f]) if (pin[f] >= 0) begin
      eo[pin[f]] = pat[f];
      ee[pin[f]] = f_oe[f] & (~pat[f] | rmode[pin[f]] & f != F_SDA & f != F_SCL);
    end
    ee = ee & {16{rc[6]}};
    pi = (ee & eo) | (~ee & ext);
    ei = '1;
    foreach (pin[f]) if (pin[f] >= 0) ei[f] = pi[pin[f]];
    `CHK(p_oe, ee)
    `CHK(p_out, eo)
    `CHK(f_in, ei)
  endtask

  task automatic cfg(input logic [7:0] a, b, c, sp, input logic [15:0] sk, md);
    seed = lfsr(lfsr(seed));
    pat <= seed[16:0];
    latch <= seed[31:16];
    seed = lfsr(seed);
    ext <= seed[15:0];
    ra = a & 8'h3f;
    rb = b & 8'h3f;
    rc = c;
    rspi = sp;
    rskip = sk;
    rmode = md;
    wb(1'b1, IDX_EN_A, a, 1'b1);
    wb(1'b1, IDX_EN_B, b, 1'b1);
    wb(1'b1, IDX_EN_C, c, 1'b1);
    wb(1'b1, IDX_SKIP_0, sk[7:0], 1'b1);
    wb(1'b1, IDX_SKIP_1, sk[15:8], 1'b1);
    wb(1'b1, IDX_MODE_0, md[7:0], 1'b1);
    wb(1'b1, IDX_MODE_1, md[15:8], 1'b1);
    wb(1'b1, IDX_SPI_CTL, sp, 1'b1);
    repeat (3) @(posedge clk_i);
    check;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    finish_test;
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, IDX_EN_A, 8'h0, 1'b1);
    `CHK(rdat, 32'h0)
    wb(1'b0, IDX_EN_B, 8'h0, 1'b1);
    `CHK(rdat, 32'h0)
    check;
    wb(1'b1, IDX_EN_A, 8'hff, 1'b1);
    wb(1'b1, IDX_EN_A, 8'h00, 1'b0);
    wb(1'b0, IDX_EN_A, 8'h0, 1'b1);
    `CHK(rdat, 32'h3f)
    wb(1'b1, IDX_EN_B, 8'hff, 1'b1);
    wb(1'b0, IDX_EN_B, 8'h0, 1'b1);
    `CHK(rdat, 32'h3f)
    wb(1'b0, 8'h10, 8'h0, 1'b1);
    `CHK(rdat, 32'h0)
    $display("test registers done");
    cfg(8'h03, 8'h3b, 8'h40, 8'h00, 16'h0000, 16'hffff);
    cfg(8'h03, 8'h3b, 8'h40, 8'h04, 16'h0000, 16'hffff);
    cfg(8'h07, 8'h3b, 8'h40, 8'h0c, 16'h030c, 16'h00f0);
    cfg(8'h3f, 8'h3f, 8'h00, 8'h04, 16'h0000, 16'hffff);
    cfg(8'h0f, 8'h00, 8'h40, 8'h00, 16'h0031, 16'hffff);
    for (int i = 0; i < 8; i++) cfg(8'h02, i[7:0], 8'h40, 8'h0, 16'h0, 16'hffff);
    for (int i = 0; i < 6; i++)
      cfg(8'h01 << i, (8'h08 << i) & 8'h38, 8'h40, 8'h0, 16'h0, 16'hffff);
    $display("test corners done");
    for (int i = 0; i < 20; i++) begin
      seed = lfsr(seed);
      cfg(seed[7:0], seed[15:8], {1'b0, seed[16], 6'h0}, {4'h0, seed[18:17], 2'h0},
          seed[31:16] | 16'h1000, ~seed[23:8]);
    end
    $display("test random done");
    finish_test;
  end
endmodule // priority_crossbar_decoder_tb
